/* File: lrd_rx_deser.sv */
// LVDS receive deserializer with alignment, crossing FIFO and AXI4-Lite.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module lrd_rx_deser
   import lrd_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic SERIAL_DATA,
   input wire logic SERIAL_BIT_CLOCK,
   input wire logic PARALLEL_WORD_CLOCK,
   input wire logic CORE_READ_CLOCK,
   input wire logic FIFO_READ,
   input wire logic DESER_RESET,
   input wire logic DELAY_ADJUST_ENABLE,
   input wire logic DELAY_STEP_UP,
   input wire logic DELAY_COUNTER_CLEAR,
   output logic [WMAX-1:0] PARALLEL_WORD,
   output logic FIFO_EMPTY,
   output logic ALIGN_LOCK,
   output logic [5:0] FINAL_TAP_REPORT,
   output logic BYPASS_CLOCK_OUT,
   output logic INPUT_BUFFER_ON,
   output logic TERMINATION_ON,
   output logic IRQ,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   function automatic logic [3:0] eff_width(input logic [3:0] w);
      eff_width = (w == 4'h0) ? W_BYPASS : ((w > WMAX_W) ? WMAX_W : w);
   endfunction : eff_width

   function automatic logic [WMAX-1:0] width_mask(input logic [3:0] n);
      width_mask = '0;
      for (int i = 0; i < WMAX; i++) begin
         width_mask[i] = (i < int'(n));
      end
   endfunction : width_mask

   function automatic logic [31:0] merge32(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      merge32 = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            merge32[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction : merge32

   // Every pin but RESETN and the AXI port is foreign to MCLK, including the three link clocks.
   logic [NSYNC-1:0] pin_bus, sy1_r, sy2_r, prev_r;
   logic [NSYNC-1:0] rise, fall;
   assign pin_bus = {DELAY_COUNTER_CLEAR, DELAY_STEP_UP, DELAY_ADJUST_ENABLE,
      DESER_RESET, FIFO_READ, CORE_READ_CLOCK, PARALLEL_WORD_CLOCK,
      SERIAL_BIT_CLOCK, SERIAL_DATA};
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         sy1_r <= '0;
         sy2_r <= '0;
         prev_r <= '0;
      end else begin
         sy1_r <= pin_bus;
         sy2_r <= sy1_r;
         prev_r <= sy2_r;
      end
   end
   assign rise = sy2_r & ~prev_r;
   assign fall = ~sy2_r & prev_r;

   lrd_ctrl_s ctrl_r;
   logic [3:0] wsel;
   logic par_rise, rd_rise, deser_clr, dynamic, auto_ok;
   lrd_dly_s dly;
   assign wsel = eff_width(ctrl_r.width);
   assign par_rise = rise[SY_PCLK];
   assign rd_rise = rise[SY_RCLK];
   assign deser_clr = sy2_r[SY_RST];
   assign dynamic = (ctrl_r.dmode == DLY_DYNAMIC);
   assign auto_ok = (ctrl_r.dmode == DLY_AUTO) && !ctrl_r.half_rate;
   // Delay controls only count on a parallel clock rising edge.
   assign dly.enable = sy2_r[SY_DEN];
   assign dly.step = par_rise && sy2_r[SY_DEN] && dynamic;
   assign dly.up = sy2_r[SY_DUP];
   assign dly.clear = par_rise && sy2_r[SY_DCLR];

   // Input buffer and tapped delay line, one MCLK per tap.
   logic din, din_old, delayed;
   logic [DLY_DEPTH-1:0] dl_r;
   logic [5:0] tap_r;
   assign din = sy2_r[SY_DATA] && ctrl_r.buf_on;
   assign din_old = dl_r[0];
   assign delayed = dl_r[tap_r[2:0]];
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         dl_r <= '0;
      end else begin
         dl_r <= {dl_r[DLY_DEPTH-2:0], din};
      end
   end

   // Alignment measures where data edges fall relative to the sample edge.
   lrd_dpa_e dpa_st_r, dpa_nxt;
   logic [3:0] since_r;
   logic [2:0] hits_r, hits_nxt, est_r, est_nxt, est;
   logic den_r, dpa_go, est_ev, lock_r, lock_entry;
   assign est = 3'(since_r - HALF_BIT - 4'h1);
   assign est_ev = rise[SY_SCLK] && (since_r < BIT_LIMIT);
   assign dpa_go = auto_ok && den_r;
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         since_r <= '0;
         den_r <= 1'b0;
      end else begin
         since_r <= (din != din_old) ? 4'h0 :
            ((since_r == 4'hF) ? since_r : since_r + 4'h1);
         den_r <= par_rise ? dly.enable : den_r;
      end
   end
   always_comb begin
      dpa_nxt = dpa_st_r;
      hits_nxt = hits_r;
      est_nxt = est_r;
      unique case (dpa_st_r)
         DPA_IDLE: begin
            hits_nxt = 3'h0;
            dpa_nxt = dpa_go ? DPA_TRAIN : DPA_IDLE;
         end
         DPA_TRAIN: begin
            if (!dpa_go) begin
               dpa_nxt = DPA_IDLE;
            end else if (est_ev) begin
               est_nxt = est;
               hits_nxt = (est == est_r) ? hits_r + 3'h1 : 3'h0;
               if ((est == est_r) && (hits_r == LOCK_HITS - 3'h1)) begin
                  dpa_nxt = DPA_LOCKED;
               end
            end
         end
         DPA_LOCKED: begin
            dpa_nxt = dpa_go ? DPA_LOCKED : DPA_IDLE;
         end
         default: begin
            dpa_nxt = DPA_IDLE;
         end
      endcase
      if (dly.clear && (ctrl_r.dmode == DLY_AUTO)) begin
         dpa_nxt = DPA_IDLE;
      end
   end
   assign lock_entry = (dpa_nxt == DPA_LOCKED) && (dpa_st_r != DPA_LOCKED);
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         dpa_st_r <= DPA_IDLE;
         hits_r <= '0;
         est_r <= '0;
         lock_r <= 1'b0;
      end else begin
         dpa_st_r <= dpa_nxt;
         hits_r <= hits_nxt;
         est_r <= est_nxt;
         lock_r <= (dpa_nxt == DPA_LOCKED);
      end
   end
   assign ALIGN_LOCK = lock_r;

   // Delay tap: manual steps in dynamic mode, training result in auto mode.
   logic [5:0] tap_nxt, final_tap_r;
   always_comb begin
      tap_nxt = tap_r;
      if (dynamic && dly.clear) begin
         tap_nxt = 6'h00;
      end else if (dly.step && dly.up && (tap_r < TAP_MAX)) begin
         tap_nxt = tap_r + 6'h01;
      end else if (dly.step && !dly.up && (tap_r != 6'h00)) begin
         tap_nxt = tap_r - 6'h01;
      end else if (lock_entry) begin
         tap_nxt = {3'h0, est};
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         tap_r <= '0;
         final_tap_r <= '0;
      end else begin
         tap_r <= tap_nxt;
         final_tap_r <= lock_entry ? {3'h0, est} : final_tap_r;
      end
   end
   assign FINAL_TAP_REPORT = final_tap_r;

   // Deserializer: the word fills from bit zero upward.
   logic smp_ev, last_bit;
   logic [WMAX-1:0] shreg_r, done_r, put_word;
   logic [3:0] bitcnt_r;
   assign smp_ev = ctrl_r.half_rate ? (rise[SY_SCLK] || fall[SY_SCLK])
      : rise[SY_SCLK];
   assign last_bit = (bitcnt_r >= wsel - 4'h1);
   always_comb begin
      put_word = shreg_r;
      for (int i = 0; i < WMAX; i++) begin
         if (i == int'(bitcnt_r)) begin
            put_word[i] = delayed;
         end
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         shreg_r <= '0;
         bitcnt_r <= '0;
         done_r <= '0;
      end else if (deser_clr) begin
         shreg_r <= '0;
         bitcnt_r <= '0;
         done_r <= '0;
      end else if (smp_ev) begin
         shreg_r <= last_bit ? '0 : put_word;
         bitcnt_r <= last_bit ? 4'h0 : bitcnt_r + 4'h1;
         done_r <= last_bit ? (put_word & width_mask(wsel)) : done_r;
      end
   end

   // Crossing FIFO; a full FIFO drops the newest word and flags it.
   logic [WMAX-1:0] mem [FIFO_DEPTH];
   logic [FIFO_AW:0] wp_r, rp_r, wp_nxt, rp_nxt, fifo_cnt;
   logic empty_now, full_now, push, pop, ovf_ev, udf_ev, rd_req;
   logic fifo_empty_r;
   logic [WMAX-1:0] word_r;
   assign rd_req = rd_rise && sy2_r[SY_RD];
   assign empty_now = (wp_r == rp_r);
   assign full_now = (wp_r[FIFO_AW] != rp_r[FIFO_AW]) &&
      (wp_r[FIFO_AW-1:0] == rp_r[FIFO_AW-1:0]);
   assign push = ctrl_r.fifo_en && par_rise && !full_now;
   assign ovf_ev = ctrl_r.fifo_en && par_rise && full_now;
   assign pop = ctrl_r.fifo_en && rd_req && !empty_now;
   assign udf_ev = ctrl_r.fifo_en && rd_req && empty_now;
   assign wp_nxt = wp_r + {{FIFO_AW{1'b0}}, push};
   assign rp_nxt = rp_r + {{FIFO_AW{1'b0}}, pop};
   assign fifo_cnt = wp_r - rp_r;
   always_ff @(posedge MCLK) begin
      if (push) begin
         mem[wp_r[FIFO_AW-1:0]] <= done_r;
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         wp_r <= '0;
         rp_r <= '0;
      end else if (deser_clr || !ctrl_r.fifo_en) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         fifo_empty_r <= 1'b1;
      end else if (deser_clr || !ctrl_r.fifo_en) begin
         fifo_empty_r <= 1'b1;
      end else if (rd_rise) begin
         fifo_empty_r <= (wp_nxt == rp_nxt);
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         word_r <= '0;
      end else if (deser_clr) begin
         word_r <= '0;
      end else if (!ctrl_r.fifo_en && par_rise) begin
         word_r <= done_r;
      end else if (pop) begin
         word_r <= mem[rp_r[FIFO_AW-1:0]];
      end
   end
   assign PARALLEL_WORD = word_r;
   assign FIFO_EMPTY = fifo_empty_r;

   // Bypass, buffer enable and termination pins.
   logic byp_r, bufon_r, term_r;
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         byp_r <= 1'b0;
         bufon_r <= 1'b0;
         term_r <= 1'b0;
      end else begin
         byp_r <= ctrl_r.bypass && (wsel == W_BYPASS) && delayed;
         bufon_r <= ctrl_r.buf_on;
         term_r <= ctrl_r.term_dyn ? ctrl_r.term_on : STATIC_TERM;
      end
   end
   assign BYPASS_CLOCK_OUT = byp_r;
   assign INPUT_BUFFER_ON = bufon_r;
   assign TERMINATION_ON = term_r;

   // AXI4-Lite slave: one write and one read in flight.
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, aw_hold_r;
   logic w_hold_r, wr_go, irq_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r, ctrl_word, status_word, rd_mux;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic wr_ctrl, wr_stat, wr_mask, wr_hit, rd_hit;
   logic [NIRQ-1:0] irq_stat_r, irq_mask_r, irq_ev, stat_nxt, mask_nxt;
   logic [31:0] w1c_word, mask_word;
   assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
   assign wr_ctrl = wr_go && (awaddr_r == OFS_CTRL);
   assign wr_stat = wr_go && (awaddr_r == OFS_IRQ_STAT);
   assign wr_mask = wr_go && (awaddr_r == OFS_IRQ_MASK);
   assign wr_hit = wr_ctrl || wr_stat || wr_mask || (awaddr_r == OFS_STATUS)
      || (awaddr_r == OFS_WORD);
   assign ctrl_word = merge32({{(32-CTRL_W){1'b0}}, ctrl_r}, wdata_r, wstrb_r);
   assign w1c_word = merge32(32'h0000_0000, wdata_r, wstrb_r);
   assign mask_word = merge32({{(32-NIRQ){1'b0}}, irq_mask_r}, wdata_r,
      wstrb_r);
   assign status_word = {20'h0_0000, fifo_cnt, tap_r, fifo_empty_r, lock_r};
   assign rd_hit = (S_AXI_ARADDR == OFS_CTRL) ||
      (S_AXI_ARADDR == OFS_STATUS) || (S_AXI_ARADDR == OFS_IRQ_STAT) ||
      (S_AXI_ARADDR == OFS_IRQ_MASK) || (S_AXI_ARADDR == OFS_WORD);
   assign rd_mux =
      (S_AXI_ARADDR == OFS_CTRL) ? {{(32-CTRL_W){1'b0}}, ctrl_r} :
      (S_AXI_ARADDR == OFS_STATUS) ? status_word :
      (S_AXI_ARADDR == OFS_IRQ_STAT) ? {{(32-NIRQ){1'b0}}, irq_stat_r} :
      (S_AXI_ARADDR == OFS_IRQ_MASK) ? {{(32-NIRQ){1'b0}}, irq_mask_r} :
      (S_AXI_ARADDR == OFS_WORD) ? {{(32-WMAX){1'b0}}, done_r} :
      32'h0000_0000;
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         awready_r <= 1'b1;
         aw_hold_r <= 1'b0;
         awaddr_r <= '0;
      end else if (S_AXI_AWVALID && awready_r) begin
         awready_r <= 1'b0;
         aw_hold_r <= 1'b1;
         awaddr_r <= S_AXI_AWADDR;
      end else begin
         aw_hold_r <= wr_go ? 1'b0 : aw_hold_r;
         awready_r <= (bvalid_r && S_AXI_BREADY) ? 1'b1 : awready_r;
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         wready_r <= 1'b1;
         w_hold_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (S_AXI_WVALID && wready_r) begin
         wready_r <= 1'b0;
         w_hold_r <= 1'b1;
         wdata_r <= S_AXI_WDATA;
         wstrb_r <= S_AXI_WSTRB;
      end else begin
         w_hold_r <= wr_go ? 1'b0 : w_hold_r;
         wready_r <= (bvalid_r && S_AXI_BREADY) ? 1'b1 : wready_r;
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (S_AXI_ARVALID && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && S_AXI_RREADY) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= ctrl_word[CTRL_W-1:0];
      end
   end

   // Sticky events: a new event outranks a clear in the same cycle.
   assign irq_ev[IRQ_LOCK] = lock_entry;
   assign irq_ev[IRQ_UNLOCK] = lock_r && (dpa_nxt != DPA_LOCKED);
   assign irq_ev[IRQ_OVF] = ovf_ev;
   assign irq_ev[IRQ_UDF] = udf_ev;
   assign stat_nxt = (irq_stat_r & ~(wr_stat ? w1c_word[NIRQ-1:0] :
      {NIRQ{1'b0}})) | irq_ev;
   assign mask_nxt = wr_mask ? mask_word[NIRQ-1:0] : irq_mask_r;
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         irq_r <= 1'b0;
      end else begin
         irq_stat_r <= stat_nxt;
         irq_mask_r <= mask_nxt;
         irq_r <= |(stat_nxt & mask_nxt);
      end
   end
   assign IRQ = irq_r;
   assign S_AXI_AWREADY = awready_r;
   assign S_AXI_WREADY = wready_r;
   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_ARREADY = arready_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;

   AST_FULL_NO_FALL: assert property (@(posedge MCLK) disable iff (!RESETN)
      (!ctrl_r.half_rate && fall[SY_SCLK] && !deser_clr)
      |=> $stable(bitcnt_r) && $stable(shreg_r))
      else $error("full rate sampled on a falling edge");
   AST_HALF_FALL: assert property (@(posedge MCLK) disable iff (!RESETN)
      (ctrl_r.half_rate && fall[SY_SCLK] && !deser_clr && $stable(ctrl_r))
      |=> (bitcnt_r == 4'h0) || (bitcnt_r == $past(bitcnt_r) + 4'h1))
      else $error("half rate missed a falling edge");
   AST_WORD_ON_PAR: assert property (@(posedge MCLK) disable iff (!RESETN)
      ($changed(word_r) && !ctrl_r.fifo_en && !$past(ctrl_r.fifo_en))
      |-> $past(par_rise) || $past(deser_clr))
      else $error("word changed off the parallel clock edge");
   AST_EMPTY_RD: assert property (@(posedge MCLK) disable iff (!RESETN)
      (ctrl_r.fifo_en && rd_rise && !deser_clr)
      |=> FIFO_EMPTY == (wp_r == rp_r))
      else $error("empty flag wrong after read clock edge");
   AST_STEP_UP: assert property (@(posedge MCLK) disable iff (!RESETN)
      (dly.step && dly.up && !dly.clear && tap_r < TAP_MAX)
      |=> tap_r == $past(tap_r) + 6'h01)
      else $error("delay step up not applied");
   AST_CLEAR: assert property (@(posedge MCLK) disable iff (!RESETN)
      (dly.clear && dynamic) |=> tap_r == 6'h00 ##1 tap_r < 6'h02)
      else $error("delay clear did not zero the tap");
   AST_BUF_OFF: assert property (@(posedge MCLK) disable iff (!RESETN)
      (!ctrl_r.buf_on) [*8] |=> dl_r == '0)
      else $error("data passed with the input buffer off");
   AST_LOCK_MODE: assert property (@(posedge MCLK) disable iff (!RESETN)
      ALIGN_LOCK |-> $past(ctrl_r.dmode) == DLY_AUTO &&
      !$past(ctrl_r.half_rate))
      else $error("lock outside full rate automatic mode");
   AST_LOCK_TAP: assert property (@(posedge MCLK) disable iff (!RESETN)
      $rose(lock_r) |-> FINAL_TAP_REPORT == tap_r)
      else $error("tap report differs from locked tap");
   AST_BYPASS: assert property (@(posedge MCLK) disable iff (!RESETN)
      (ctrl_r.bypass && wsel == W_BYPASS) |=> BYPASS_CLOCK_OUT ==
      $past(delayed))
      else $error("bypass output does not follow the lane");
endmodule : lrd_rx_deser

/* File: lrd_pkg.sv */
// Constants, types and register map of the LVDS receive deserializer.
// Function
// - Full rate: sample serial data on serial clock rising edges only.
// - Half rate: sample serial data on both serial clock edges.
// - Word width programmable up to ten bits, output bus matches it.
// - Each word reaches the core on the parallel clock rising edge.
// - Optional eight-entry FIFO moves words into the core read clock.
// - With FIFO on, empty flag follows read clock while nothing stored.
// - Deserializer reset clears FIFO and deserializer.
// - Input buffer enable: one turns receiver on, zero turns it off.
// - Dynamic termination: control one connects, zero disconnects.
// - Automatic alignment raises lock output once training has locked.
// - Delay adjust enable, on parallel clock, activates stepping or alignment.
// - Dynamic mode only: step input one raises, zero lowers delay.
// - Delay clear zeroes counter or restarts alignment, per delay mode.
// - Six-bit report shows the delay setting chosen at lock.
// - Alignment centres sampling in the bit, full rate only.
// - Bypass with width one routes received signal to alternate output.
package lrd_pkg;
   localparam int MCLK_NS = 40;
   localparam int SBIT_NS = 320;
   localparam int BIT_MCLKS = (SBIT_NS + MCLK_NS - 1) / MCLK_NS;
   localparam logic [3:0] BIT_LIMIT = 4'(BIT_MCLKS);
   localparam logic [3:0] HALF_BIT = 4'(BIT_MCLKS / 2);
   localparam int WMAX = 10;
   localparam logic [3:0] WMAX_W = 4'hA;
   localparam logic [3:0] W_BYPASS = 4'h1;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_AW = 3;
   localparam int DLY_DEPTH = 8;
   localparam logic [5:0] TAP_MAX = 6'h07;
   localparam logic [2:0] LOCK_HITS = 3'h4;
   localparam logic STATIC_TERM = 1'b1;
   localparam int NSYNC = 9;
   localparam int SY_DATA = 0;
   localparam int SY_SCLK = 1;
   localparam int SY_PCLK = 2;
   localparam int SY_RCLK = 3;
   localparam int SY_RD = 4;
   localparam int SY_RST = 5;
   localparam int SY_DEN = 6;
   localparam int SY_DUP = 7;
   localparam int SY_DCLR = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_WORD = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int NIRQ = 4;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_UNLOCK = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_UDF = 3;
   typedef enum logic [1:0] {
      DLY_STATIC = 2'b00,
      DLY_DYNAMIC = 2'b01,
      DLY_AUTO = 2'b10
   } lrd_dmode_e;
   typedef enum logic [1:0] {
      DPA_IDLE = 2'b00,
      DPA_TRAIN = 2'b01,
      DPA_LOCKED = 2'b10
   } lrd_dpa_e;
   typedef struct packed {
      logic [3:0] width;
      logic half_rate;
      logic fifo_en;
      lrd_dmode_e dmode;
      logic bypass;
      logic buf_on;
      logic term_dyn;
      logic term_on;
   } lrd_ctrl_s;
   localparam int CTRL_W = $bits(lrd_ctrl_s);
   localparam lrd_ctrl_s CTRL_RST = 12'h805;
   typedef struct packed {
      logic enable;
      logic step;
      logic up;
      logic clear;
   } lrd_dly_s;
endpackage : lrd_pkg

/* File: lrd_tx_model.sv */
// Remote LVDS transmitter model with free-running PLL clocks and one lane.
`timescale 1ns/1ps
module lrd_tx_model (
   input wire logic level,
   input wire logic [3:0] width,
   output logic sdata,
   output logic sclk,
   output logic pclk
);
   int n = 0;
   initial sclk = 1'h0;
   // Data moves on the falling edge so that a rising edge samples mid-bit.
   always #160 sclk = ~sclk;
   always @(negedge sclk) begin
      sdata <= level;
      n <= (n + 1 >= int'(width)) ? 0 : n + 1;
      pclk <= n < int'(width) / 2;
   end
endmodule : lrd_tx_model

/* File: testbench.sv */
// Self-checking bench for the LVDS receive deserializer.
`timescale 1ns/1ps
module testbench;
   import lrd_pkg::*;
   logic mclk = 0, rstn = 0, level = 0, rclk = 0, frd = 0, drst = 0;
   logic den = 0, dup = 0, dclr = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   logic [3:0] wid = 4'h8;
   logic [11:0] cw [3] = '{12'h804, 12'hA84, 12'h10C};
   logic [10:0] ex [3] = '{11'h0FF, 11'h3FF, 11'h400};
   wire sd, sc, pc, fe, byp, bon, ton, irq, awr, wrdy, bv, arr, rv;
   wire [9:0] pw;
   wire lk;
   wire [5:0] rpt;
   wire [1:0] rresp;
   wire [31:0] rdata;
   int num_errors = 0, comparisons = 0;
   always #20 mclk = ~mclk;
   lrd_tx_model u_lrd_tx_model (.level(level), .width(wid), .sdata(sd),
      .sclk(sc), .pclk(pc));
   lrd_rx_deser u_lrd_rx_deser (.MCLK(mclk), .RESETN(rstn),
      .SERIAL_DATA(sd), .SERIAL_BIT_CLOCK(sc), .PARALLEL_WORD_CLOCK(pc),
      .CORE_READ_CLOCK(rclk), .FIFO_READ(frd), .DESER_RESET(drst),
      .DELAY_ADJUST_ENABLE(den), .DELAY_STEP_UP(dup),
      .DELAY_COUNTER_CLEAR(dclr), .PARALLEL_WORD(pw), .FIFO_EMPTY(fe),
      .ALIGN_LOCK(lk), .FINAL_TAP_REPORT(rpt), .BYPASS_CLOCK_OUT(byp),
      .INPUT_BUFFER_ON(bon), .TERMINATION_ON(ton), .IRQ(irq),
      .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrdy), .S_AXI_BRESP(), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
   task automatic end_sim;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // Readiness is sampled mid-cycle, so a release never races the edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [2:0] g;
      logic done;
      done = 0;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      while (!done) begin
         @(negedge mclk);
         g = {awr, wrdy, bv};
         @(posedge mclk);
         if (g[2]) awv <= 1'h0;
         if (g[1]) wv <= 1'h0;
         done = g[0];
      end
      br <= 1'h0;
      tick(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      logic g;
      logic done;
      logic [33:0] v;
      done = 0;
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      while (!done) begin
         @(negedge mclk);
         g = arr;
         done = rv;
         v = {rresp, rdata};
         @(posedge mclk);
         if (g) arv <= 1'h0;
      end
      rr <= 1'h0;
      tick(1);
      chk(v, e);
   endtask : rd
   task automatic rpulse(input int n);
      repeat (n) begin
         rclk <= ~rclk;
         tick(4);
      end
   endtask : rpulse
   initial begin
      #1_000_000;
      num_errors++;
      end_sim();
   end
   initial begin
      tick(12);
      rstn <= 1'h1;
      tick(1);
      chk(fe, 1'h1);
      rd(OFS_CTRL, 34'h0_0000_0805);
      rd(8'h40, 34'h2_0000_0000);
      wr(OFS_CTRL, 32'h0000_0806);
      tick(3);
      chk({bon, ton}, 2'h2);
      wr(OFS_CTRL, 32'h0000_0803);
      tick(3);
      chk({bon, ton}, 2'h1);
      // Constant lanes keep the check free of the unaligned word framing.
      for (int i = 0; i < 3; i++) begin
         wid <= cw[i][11:8];
         wr(OFS_CTRL, {20'h0_0000, cw[i]});
         for (int l = 1; l >= 0; l--) begin
            level <= l[0];
            tick(400);
            chk({byp, pw} & (i == 2 ? 11'h400 : 11'h7FF), l ? ex[i] : 0);
         end
      end
      wid <= 4'h8;
      wr(OFS_CTRL, 32'h0000_0814);
      den <= 1'h1;
      dup <= 1'h1;
      tick(700);
      rd(OFS_STATUS, 34'h0_0000_001E);
      den <= 1'h0;
      dup <= 1'h0;
      tick(200);
      rd(OFS_STATUS, 34'h0_0000_001E);
      dclr <= 1'h1;
      tick(140);
      dclr <= 1'h0;
      rd(OFS_STATUS, 34'h0_0000_0002);
      // A lane that toggles every bit gives the alignment edges to measure.
      wr(OFS_CTRL, 32'h0000_0824);
      den <= 1'h1;
      repeat (40) begin
         level <= ~level;
         tick(8);
      end
      chk({lk, rpt}, 7'h46);
      den <= 1'h0;
      tick(100);
      rd(OFS_IRQ_STAT, 34'h0_0000_0003);
      wr(OFS_IRQ_STAT, 32'h0000_0003);
      wr(OFS_IRQ_MASK, 32'h0000_0004);
      wr(OFS_CTRL, 32'h0000_0844);
      tick(700);
      chk(irq, 1'h1);
      // While the FIFO runs, the empty flag only moves on a read clock rising edge.
      rpulse(2);
      rd(OFS_STATUS, 34'h0_0000_0818);
      frd <= 1'h1;
      rpulse(24);
      frd <= 1'h0;
      rd(OFS_IRQ_STAT, 34'h0_0000_000C);
      wr(OFS_IRQ_STAT, 32'h0000_000C);
      rd(OFS_IRQ_STAT, 34'h0_0000_0000);
      chk(irq, 1'h0);
      drst <= 1'h1;
      rpulse(4);
      chk({fe, pw}, 11'h400);
      drst <= 1'h0;
      end_sim();
   end
endmodule : testbench
